// >>> inc/bps_pkg.sv
// Package for the pressure sensor two-wire client and its host controller.
// Assumes both ends run on one 125 MHz clock with a synchronous reset.
package bps_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SCL_KHZ = 400;
  localparam int unsigned QTR_CYCLES = CLK_HZ / (SCL_KHZ * 1000 * 4);
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [6:0] DEV_ADDR = 7'h62;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  // Identification value is arbitrary.
  localparam logic [7:0] ID_VALUE = 8'h5a;
  localparam logic [7:0] FACTORY_P_OFS = 8'h00;
  localparam logic [7:0] FACTORY_T_OFS = 8'h00;
  // Client register indices.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_P_MSB = 8'h01;
  localparam logic [7:0] REG_P_CSB = 8'h02;
  localparam logic [7:0] REG_P_LSB = 8'h03;
  localparam logic [7:0] REG_T_MSB = 8'h04;
  localparam logic [7:0] REG_T_LSB = 8'h05;
  localparam logic [7:0] REG_FIFO_STAT = 8'h06;
  localparam logic [7:0] REG_FIFO_DATA = 8'h07;
  localparam logic [7:0] REG_ID = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_IVL = 8'h11;
  localparam logic [7:0] REG_WMARK = 8'h12;
  localparam logic [7:0] REG_INTCFG = 8'h13;
  localparam logic [7:0] REG_P_OFS = 8'h14;
  localparam logic [7:0] REG_T_OFS = 8'h15;
  // Fields of the primary control register.
  localparam int unsigned CTRL_ACTIVE = 0;
  localparam int unsigned CTRL_ONESHOT = 1;
  localparam int unsigned CTRL_AUTO = 2;
  localparam logic [2:0] FIFO_LAST_BYTE = 3'd4;
  // Host controller AXI4-Lite map.
  localparam logic [31:0] AXI_CMD = 32'h0000_0000;
  localparam logic [31:0] AXI_STATUS = 32'h0000_0004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] STEP_START = 3'd0;
  localparam logic [2:0] STEP_ADDR_W = 3'd1;
  localparam logic [2:0] STEP_INDEX = 3'd2;
  localparam logic [2:0] STEP_DATA_RS = 3'd3;
  localparam logic [2:0] STEP_ADDR_R = 3'd4;
  localparam logic [2:0] STEP_READ = 3'd5;
  localparam logic [2:0] STEP_STOP = 3'd6;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_ACK = 3'b010,
    D_RX = 3'b011, D_TX = 3'b100, D_TXACK = 3'b101
  } bps_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_COND = 2'b01, H_BYTE = 2'b10
  } bps_host_state_t;
endpackage

// >>> inc/bps_i2c_if.sv
// Two-wire link between the sensor client and its host controller.
// Both lines are open drain; an enabled driver pulls low, else pull-up.
`timescale 1ns/1ns
`default_nettype none
interface bps_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// >>> rtl/bps_sensor_client.sv
// Sensor end: two-wire client, register file, mode control and sample FIFO.
// Assumes SCL and SDA arrive asynchronously and the measurement engine
// answers on ref_clk_i.
//
// The register indices and the placing of the fields were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bps_sensor_client import bps_pkg::*; #(
  parameter int unsigned SEC_TICKS = SEC_CYCLES,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Two-wire link.
  bps_i2c_if.device bus,
  // Measurement engine.
  output logic meas_req_o,
  input wire logic meas_valid_i,
  input wire logic [19:0] meas_p_i,
  input wire logic [15:0] meas_t_i,
  output logic analog_en_o,
  // Interrupt outputs.
  output logic interrupt_out_first_o,
  output logic interrupt_out_second_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    bps_dev_state_t st;
    logic [3:0] bitc;
    logic [7:0] sreg;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic [2:0] fbyte;
    logic sda_oe;
    logic [2:0] ctrl;
    logic [3:0] ivl;
    logic [5:0] wm;
    logic [3:0] icfg;
    logic [7:0] pofs;
    logic [7:0] tofs;
    logic [19:0] p;
    logic [15:0] t;
    logic drdy;
    logic ovf;
    logic wmf;
    logic [DEPTH-1:0][35:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [31:0] sec;
    logic [14:0] secs;
    logic busy;
    logic req;
    logic interrupt_out_first;
    logic interrupt_out_second;
  } bps_client_t;

  bps_client_t r;
  bps_client_t next_r;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;
  logic ld;
  logic wr;
  logic push;
  logic pop;
  logic due;
  logic [7:0] b;

  function automatic logic [7:0] rd_byte(input bps_client_t s, input logic [7:0] a);
    logic [35:0] h;
    h = s.mem[s.rp];
    case (a)
      REG_STATUS: rd_byte = {5'h00, s.ovf, s.wmf, s.drdy};
      REG_P_MSB: rd_byte = s.p[19:12];
      REG_P_CSB: rd_byte = s.p[11:4];
      REG_P_LSB: rd_byte = {s.p[3:0], 4'h0};
      REG_T_MSB: rd_byte = s.t[15:8];
      REG_T_LSB: rd_byte = s.t[7:0];
      REG_FIFO_STAT: rd_byte = {s.ovf, s.wmf, 6'(s.cnt)};
      REG_FIFO_DATA: begin
        case (s.fbyte)
          3'd0: rd_byte = h[35:28];
          3'd1: rd_byte = h[27:20];
          3'd2: rd_byte = {h[19:16], 4'h0};
          3'd3: rd_byte = h[15:8];
          default: rd_byte = h[7:0];
        endcase
      end
      REG_ID: rd_byte = ID_VALUE;
      REG_CTRL: rd_byte = {5'h00, s.ctrl};
      REG_IVL: rd_byte = {4'h0, s.ivl};
      REG_WMARK: rd_byte = {2'h0, s.wm};
      REG_INTCFG: rd_byte = {4'h0, s.icfg};
      REG_P_OFS: rd_byte = s.pofs;
      REG_T_OFS: rd_byte = s.tofs;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // Only the second and third synchroniser stages feed the detectors.
  assign start_c = r.scl_s[1] && r.scl_s[2] && !r.sda_s[1] && r.sda_s[2];
  assign stop_c = r.scl_s[1] && r.scl_s[2] && r.sda_s[1] && !r.sda_s[2];
  assign rise = r.scl_s[1] && !r.scl_s[2];
  assign fall = !r.scl_s[1] && r.scl_s[2];

  always_comb begin
    next_r = r;
    ld = 1'b0;
    wr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    due = 1'b0;
    b = 8'h00;
    next_r.scl_s = {r.scl_s[1:0], bus.scl};
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    next_r.req = 1'b0;
    if (stop_c) begin
      next_r.st = D_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (start_c) begin
      next_r.st = D_ADDR;
      next_r.bitc = 4'h0;
      next_r.first = 1'b1;
      next_r.sda_oe = 1'b0;
    end else if (rise) begin
      case (r.st)
        D_ADDR, D_RX: begin
          next_r.sreg = {r.sreg[6:0], r.sda_s[1]};
          next_r.bitc = r.bitc + 4'h1;
        end
        D_TXACK: next_r.nack = r.sda_s[1];
        default: ;
      endcase
    end else if (fall) begin
      case (r.st)
        D_ADDR: begin
          if (r.bitc == 4'h8) begin
            // Acknowledge only our own address, never the general call.
            if (r.sreg[7:1] == DEV_ADDR && r.sreg[7:1] != GCALL_ADDR) begin
              next_r.st = D_ACK;
              next_r.sda_oe = 1'b1;
              next_r.rw = r.sreg[0];
            end else begin
              next_r.st = D_IDLE;
            end
          end
        end
        D_RX: begin
          if (r.bitc == 4'h8) begin
            if (r.first) begin
              next_r.ptr = r.sreg;
              next_r.first = 1'b0;
            end else begin
              wr = 1'b1;
              next_r.ptr = r.ptr + 8'h01;
            end
            next_r.st = D_ACK;
            next_r.sda_oe = 1'b1;
          end
        end
        D_ACK: begin
          if (r.rw) begin
            ld = 1'b1;
          end else begin
            next_r.sda_oe = 1'b0;
            next_r.bitc = 4'h0;
            next_r.st = D_RX;
          end
        end
        D_TX: begin
          // Next bit is driven on the falling edge; SCL is never held.
          if (r.bitc == 4'h7) begin
            next_r.sda_oe = 1'b0;
            next_r.st = D_TXACK;
          end else begin
            next_r.bitc = r.bitc + 4'h1;
            next_r.sreg = {r.sreg[6:0], 1'b0};
            next_r.sda_oe = !r.sreg[6];
          end
        end
        D_TXACK: begin
          if (!r.nack) begin
            ld = 1'b1;
          end else begin
            next_r.st = D_IDLE;
          end
        end
        default: ;
      endcase
    end
    if (ld) begin
      b = rd_byte(r, r.ptr);
      next_r.sreg = b;
      next_r.sda_oe = !b[7];
      next_r.bitc = 4'h0;
      next_r.st = D_TX;
      if (r.ptr == REG_FIFO_DATA) begin
        next_r.fbyte = (r.fbyte == FIFO_LAST_BYTE) ? 3'd0 : r.fbyte + 3'd1;
        pop = (r.fbyte == FIFO_LAST_BYTE) && (r.cnt != '0);
      end else begin
        next_r.ptr = r.ptr + 8'h01;
      end
      if (r.ptr == REG_P_MSB) next_r.drdy = 1'b0;
      if (r.ptr == REG_FIFO_STAT) begin
        next_r.wmf = 1'b0;
        next_r.ovf = 1'b0;
      end
    end
    if (wr) begin
      case (r.ptr)
        REG_CTRL: begin
          next_r.ctrl = r.sreg[2:0];
          if (r.sreg[CTRL_ONESHOT]) next_r.ctrl[CTRL_ACTIVE] = 1'b1;
        end
        REG_IVL: next_r.ivl = r.sreg[3:0];
        REG_WMARK: next_r.wm = r.sreg[5:0];
        REG_INTCFG: next_r.icfg = r.sreg[3:0];
        REG_P_OFS: next_r.pofs = r.sreg;
        REG_T_OFS: next_r.tofs = r.sreg;
        default: ;
      endcase
    end
    // Interval timer counts whole seconds; interval is 2^ivl seconds.
    if (r.ctrl[CTRL_ACTIVE] && r.ctrl[CTRL_AUTO]) begin
      if (r.sec == SEC_TICKS - 1) begin
        next_r.sec = 32'h0;
        if (r.secs == 15'((16'h1 << r.ivl) - 16'h1)) begin
          next_r.secs = 15'h0;
          due = 1'b1;
        end else begin
          next_r.secs = r.secs + 15'h1;
        end
      end else begin
        next_r.sec = r.sec + 32'h1;
      end
    end else begin
      next_r.sec = 32'h0;
      next_r.secs = 15'h0;
    end
    if (r.ctrl[CTRL_ACTIVE] && !r.busy && (r.ctrl[CTRL_AUTO] ? due : 1'b1)) begin
      next_r.req = 1'b1;
      next_r.busy = 1'b1;
    end
    if (meas_valid_i && r.busy) begin
      next_r.busy = 1'b0;
      next_r.p = meas_p_i + {{12{r.pofs[7]}}, r.pofs};
      next_r.t = meas_t_i + {{8{r.tofs[7]}}, r.tofs};
      next_r.drdy = 1'b1;
      if (r.ctrl[CTRL_ONESHOT]) begin
        next_r.ctrl[CTRL_ONESHOT] = 1'b0;
        next_r.ctrl[CTRL_ACTIVE] = 1'b0;
      end
      if (r.ctrl[CTRL_AUTO]) begin
        if (r.cnt == (AW+1)'(DEPTH) && !pop) begin
          next_r.ovf = 1'b1;
        end else begin
          push = 1'b1;
          next_r.mem[r.wp] = {next_r.p, next_r.t};
          next_r.wp = r.wp + 1'b1;
        end
      end
    end
    if (pop) next_r.rp = r.rp + 1'b1;
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (r.wm != 6'h0 && next_r.cnt >= (AW+1)'(r.wm)) next_r.wmf = 1'b1;
    next_r.interrupt_out_first = (r.icfg[0] && next_r.drdy) || (r.icfg[1] && (next_r.wmf || next_r.ovf));
    next_r.interrupt_out_second = (r.icfg[2] && next_r.drdy) || (r.icfg[3] && (next_r.wmf || next_r.ovf));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.st <= D_IDLE;
      r.pofs <= FACTORY_P_OFS;
      r.tofs <= FACTORY_T_OFS;
    end else begin
      r <= next_r;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = r.sda_oe;
  assign meas_req_o = r.req;
  assign analog_en_o = r.ctrl[CTRL_ACTIVE];
  assign interrupt_out_first_o = r.interrupt_out_first;
  assign interrupt_out_second_o = r.interrupt_out_second;
endmodule // bps_sensor_client
`default_nettype wire

// >>> rtl/bps_host_ctrl.sv
// Host end: AXI4-Lite slave that runs one register write or read on the link.
// Assumes the client shares the open-drain lines through the interface.
`timescale 1ns/1ns
`default_nettype none
module bps_host_ctrl import bps_pkg::*; #(
  parameter int unsigned QTR = QTR_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Two-wire link.
  bps_i2c_if.host bus,
  // AXI4-Lite write channels.
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels.
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    bps_host_state_t st;
    logic [2:0] step;
    logic [1:0] q;
    logic [15:0] cnt;
    logic [3:0] bitc;
    logic [8:0] sreg;
    logic [7:0] rsh;
    logic smp;
    logic busy;
    logic nack;
    logic rd;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic scl_oe;
    logic sda_oe;
    logic aw_got;
    logic w_got;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bps_host_t;

  bps_host_t r;
  bps_host_t next_r;
  logic qend;

  // Loads the state for one step of the transaction.
  function automatic bps_host_t enter(input bps_host_t s, input logic [2:0] stp);
    bps_host_t o;
    o = s;
    o.step = stp;
    o.q = 2'd0;
    o.cnt = 16'h0;
    o.bitc = 4'h0;
    o.st = (stp == STEP_START || stp == STEP_STOP || (stp == STEP_DATA_RS && s.rd)) ?
           H_COND : H_BYTE;
    case (stp)
      STEP_ADDR_W: o.sreg = {DEV_ADDR, 1'b0, 1'b1};
      STEP_INDEX: o.sreg = {s.idx, 1'b1};
      STEP_DATA_RS: o.sreg = {s.wdat, 1'b1};
      STEP_ADDR_R: o.sreg = {DEV_ADDR, 1'b1, 1'b1};
      default: o.sreg = 9'h1ff;
    endcase
    enter = o;
  endfunction

  assign qend = (r.cnt == 16'(QTR - 1));

  always_comb begin
    next_r = r;
    next_r.scl_s = {r.scl_s[1:0], bus.scl};
    next_r.sda_s = {r.sda_s[1:0], bus.sda};
    if (r.st != H_IDLE) begin
      // In the second and third quarters, time runs only once SCL is seen high.
      if (r.q == 2'd0 || r.q == 2'd3 || r.scl_s[2]) begin
        next_r.cnt = r.cnt + 16'h1;
      end
      if (qend) begin
        next_r.cnt = 16'h0;
        next_r.q = r.q + 2'd1;
        if (r.q == 2'd2) next_r.smp = r.sda_s[2];
        if (r.q == 2'd3) begin
          if (r.st == H_BYTE && r.bitc != 4'h8) begin
            next_r.bitc = r.bitc + 4'h1;
            next_r.sreg = {r.sreg[7:0], 1'b1};
            next_r.rsh = {r.rsh[6:0], r.smp};
          end else if (r.st == H_BYTE && r.smp && r.step != STEP_READ) begin
            next_r.nack = 1'b1;
            next_r = enter(next_r, STEP_STOP);
          end else if (r.step == STEP_STOP) begin
            next_r.st = H_IDLE;
            next_r.busy = 1'b0;
            if (r.rd && !r.nack) next_r.rdat = r.rsh;
          end else if (r.step == STEP_DATA_RS && !r.rd) begin
            next_r = enter(next_r, STEP_STOP);
          end else begin
            next_r = enter(next_r, r.step + 3'd1);
          end
        end
      end
    end
    if (s_axi_awvalid_i && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata_i;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = (r.awaddr == AXI_CMD || r.awaddr == AXI_STATUS) ?
                     RESP_OKAY : RESP_SLVERR;
      if (r.awaddr == AXI_CMD && !r.busy) begin
        next_r.wdat = r.wdata[7:0];
        next_r.idx = r.wdata[15:8];
        next_r.rd = r.wdata[16];
        next_r.busy = 1'b1;
        next_r.nack = 1'b0;
        next_r = enter(next_r, STEP_START);
      end
    end
    if (r.bvalid && s_axi_bready_i) next_r.bvalid = 1'b0;
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;
    if (s_axi_arvalid_i && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = (s_axi_araddr_i == AXI_CMD || s_axi_araddr_i == AXI_STATUS) ?
                     RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr_i == AXI_CMD) begin
        next_r.rdata = {15'h0, r.rd, r.idx, r.wdat};
      end else if (s_axi_araddr_i == AXI_STATUS) begin
        next_r.rdata = {16'h0, r.rdat, 6'h0, r.nack, r.busy};
      end else begin
        next_r.rdata = 32'h0;
      end
    end
    if (r.rvalid && s_axi_rready_i) next_r.rvalid = 1'b0;
    next_r.arready = !next_r.rvalid;
    // Line drive for the coming quarter.
    case (next_r.st)
      H_BYTE: begin
        next_r.scl_oe = (next_r.q == 2'd0 || next_r.q == 2'd3);
        next_r.sda_oe = !next_r.sreg[8];
      end
      H_COND: begin
        next_r.scl_oe = (next_r.step == STEP_STOP) ? (next_r.q == 2'd0) :
                        (next_r.q == 2'd0 || next_r.q == 2'd3);
        next_r.sda_oe = (next_r.step == STEP_STOP) ? (next_r.q < 2'd2) :
                        (next_r.q >= 2'd2);
      end
      default: begin
        next_r.scl_oe = 1'b0;
        next_r.sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.st <= H_IDLE;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = r.sda_oe;
  assign s_axi_awready_o = r.awready;
  assign s_axi_wready_o = r.wready;
  assign s_axi_bresp_o = r.bresp;
  assign s_axi_bvalid_o = r.bvalid;
  assign s_axi_arready_o = r.arready;
  assign s_axi_rdata_o = r.rdata;
  assign s_axi_rresp_o = r.rresp;
  assign s_axi_rvalid_o = r.rvalid;
endmodule // bps_host_ctrl
`default_nettype wire

// >>> test/bps_assertions.sv
// Link checker: framing, acknowledge and line release on the shared wires.
// Assumes the resolved lines and the enables of one link interface.
`timescale 1ns/1ns
`default_nettype none
module bps_assertions import bps_pkg::*; #(
  parameter int unsigned QTR = QTR_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Link.
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe
);
  localparam int LOW_MAX = 8 * QTR;
  logic ps, pd, dir;
  logic [3:0] bits, nbyte;
  logic [7:0] sh;
  wire logic rise = scl && !ps;
  wire logic ack = rise && bits == 4'd8;
  // Bit and byte position since the last START, as seen on the wires.
  always_ff @(posedge ref_clk_i) begin
    ps <= scl;
    pd <= sda;
    if (!rstn_i || (scl && ps && pd && !sda)) begin
      bits <= 4'd0;
      nbyte <= 4'd0;
      dir <= 1'b0;
    end else if (rise) begin
      bits <= (bits == 4'd8) ? 4'd0 : bits + 4'd1;
      if (bits == 4'd8) nbyte <= nbyte + 4'd1;
      else sh <= {sh[6:0], sda};
      if (bits == 4'd8 && nbyte == 4'd0) dir <= sh[0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_reset_idle;
    $rose(rstn_i) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
  property p_steady;
    scl && ps |-> $stable(dev_sda_oe);
  endproperty
  a_steady: assert property (p_steady) else $error("client moved SDA in high");
  property p_stop_free;
    scl && ps && !pd && sda |-> (!dev_sda_oe) [*3];
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("SDA held after STOP");
  property p_scl_low;
    $rose(host_scl_oe) |-> ##[1:LOW_MAX] !host_scl_oe;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("SCL low too long");
  property p_addr;
    ack && nbyte == 4'd0 |-> sh[7:1] == DEV_ADDR;
  endproperty
  a_addr: assert property (p_addr) else $error("wrong target address");
  property p_addr_ack;
    ack && nbyte == 4'd0 |-> dev_sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_wr_ack;
    ack && nbyte != 4'd0 && !dir |-> dev_sda_oe && !host_sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
  property p_rd_rel;
    ack && nbyte != 4'd0 && dir |-> !dev_sda_oe;
  endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("client holds SDA in ack");
  property p_ack_hold;
    ack && !dir |-> (!sda) [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not stable low");
endmodule // bps_assertions
`default_nettype wire

// >>> test/testbench.sv
// Bench: host controller and sensor client joined by one link interface.
// Assumes short interval and quarter counts to keep the run brief.
`timescale 1ns/1ns
`default_nettype none
module testbench import bps_pkg::*;;
  logic clk = 0, rstn = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic aw_r, w_r, b_v, ar_r, r_v, m_req, m_v = 0, aen, auto_on = 0;
  logic [31:0] aw_a = 0, w_d = 0, ar_a = 0, r_d, s;
  logic [1:0] b_s, r_s, r;
  logic [19:0] mp = 0, lp;
  logic [15:0] mt = 0, lt;
  logic [7:0] q, v, mdl [0:255];
  logic [39:0] f;
  logic i1, i2;
  logic [7:0] idx [7] = '{REG_ID, REG_IVL, REG_WMARK, REG_INTCFG, REG_P_OFS, REG_T_OFS, 8'h20};
  logic [19:0] qp[$];
  logic [15:0] qt[$];
  int n_errors = 0, compares = 0;
  bps_i2c_if bus_if();
  bps_sensor_client #(.SEC_TICKS(50), .DEPTH(FIFO_DEPTH)) bps_sensor_client_inst (
    .ref_clk_i(clk), .rstn_i(rstn), .bus(bus_if), .meas_req_o(m_req), .meas_valid_i(m_v),
    .meas_p_i(mp), .meas_t_i(mt), .analog_en_o(aen), .interrupt_out_first_o(i1),
    .interrupt_out_second_o(i2));
  bps_host_ctrl #(.QTR(8)) bps_host_ctrl_inst (.ref_clk_i(clk), .rstn_i(rstn), .bus(bus_if),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r), .s_axi_wdata_i(w_d),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r), .s_axi_bresp_o(b_s),
    .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
    .s_axi_arready_o(ar_r), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_s), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r));
  bps_assertions #(.QTR(8)) bps_assertions_inst (.ref_clk_i(clk), .rstn_i(rstn),
    .scl(bus_if.scl), .sda(bus_if.sda), .host_scl_oe(bus_if.host_scl_oe),
    .host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe));
  initial begin
    forever #4 clk = ~clk;
  end
  // Measurement engine stand-in; the FIFO model keeps what autonomous mode stores.
  always @(posedge clk) begin
    m_v <= m_req;
    if (m_req) mp <= 20'($urandom);
    if (m_req) mt <= 16'($urandom);
    if (m_v && auto_on && qp.size() < FIFO_DEPTH) qp.push_back(mp);
    if (m_v && auto_on && qt.size() < FIFO_DEPTH) qt.push_back(mt);
    if (m_v) lp = mp;
    if (m_v) lt = mt;
  end
  function automatic logic [39:0] frame(input logic [19:0] p, input logic [15:0] t);
    return {p + {{12{mdl[REG_P_OFS][7]}}, mdl[REG_P_OFS]}, 4'h0,
            t + {{8{mdl[REG_T_OFS][7]}}, mdl[REG_T_OFS]}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v);
    r = b_s;
    b_r <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v);
    s = r_d;
    r = r_s;
    r_r <= 1'b0;
  endtask
  task automatic link(input logic [7:0] i, input logic [7:0] d, input logic rd);
    axw(AXI_CMD, {15'h0, rd, i, d});
    chk(r, RESP_OKAY);
    do axr(AXI_STATUS); while (s[0] !== 1'b0);
    chk(s[1:0], 2'b00);
    q = s[15:8];
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
    link(i, 8'h00, 1'b1);
    chk(q, e);
  endtask
  task automatic summarize();
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(51279));
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[REG_ID] = ID_VALUE;
    mdl[REG_P_OFS] = FACTORY_P_OFS;
    mdl[REG_T_OFS] = FACTORY_T_OFS;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    axr(32'h8);
    chk(s, 32'h0);
    chk(r, RESP_SLVERR);
    axw(32'hc, $urandom);
    chk(r, RESP_SLVERR);
    for (int p = 0; p < 2; p++) begin
      foreach (idx[k]) begin
        v = 8'($urandom);
        if (p == 1) link(idx[k], v, 1'b0);
        // Bits above a field's width are dropped on write and read back as zero.
        if (p == 1 && idx[k] >= REG_IVL && idx[k] <= REG_T_OFS) begin
          mdl[idx[k]] = v & ((idx[k] == REG_IVL || idx[k] == REG_INTCFG) ? 8'h0f :
                             (idx[k] == REG_WMARK) ? 8'h3f : 8'hff);
        end
        rdchk(idx[k], mdl[idx[k]]);
      end
    end
    link(REG_CTRL, 8'h02, 1'b0);
    wait (aen === 1'b0);
    rdchk(REG_CTRL, 8'h00);
    f = frame(lp, lt);
    for (int k = 0; k < 5; k++) rdchk(REG_P_MSB + 8'(k), f[39 - 8 * k -: 8]);
    mdl[REG_WMARK] = 8'h10;
    link(REG_WMARK, 8'h10, 1'b0);
    link(REG_IVL, 8'h00, 1'b0);
    auto_on = 1'b1;
    link(REG_CTRL, 8'h05, 1'b0);
    wait (qp.size() == FIFO_DEPTH);
    repeat (200) @(posedge clk);
    link(REG_CTRL, 8'h00, 1'b0);
    auto_on = 1'b0;
    rdchk(REG_FIFO_STAT, 8'he0);
    f = frame(qp[0], qt[0]);
    for (int k = 0; k < 5; k++) rdchk(REG_FIFO_DATA, f[39 - 8 * k -: 8]);
    rdchk(REG_FIFO_STAT, 8'h5f);
    // Watermark flag stays set and data-ready is still set from autonomous captures.
    link(REG_INTCFG, 8'h08, 1'b0);
    chk({30'h0, i1, i2}, 32'h1);
    link(REG_INTCFG, 8'h01, 1'b0);
    chk({30'h0, i1, i2}, 32'h2);
    summarize();
  end
endmodule // testbench
`default_nettype wire
